//--- verilog/pscr_pkg.sv
// Package for the processor status and control register bank.
// Assumes one 200 MHz clock and a plain strobe register port.
package pscr_pkg;

   // Status word layout, bit 31 first
   typedef struct packed {
      logic [3:0] coproc_usable;
      logic rsv27;
      logic fp_reg_count_sel;
      logic [1:0] rsv25;
      logic debug_vector_sel;
      logic boot_vector_sel;
      logic [2:0] rsv21;
      logic cache_hit_flag;
      logic ei_any_mode;
      logic irq_enable_gate;
      logic irq_mask_timer;
      logic [1:0] rsv14;
      logic bus_err_mask;
      logic [1:0] irq_mask_ext;
      logic [4:0] rsv9;
      logic [1:0] mode_sel;
      logic error_level;
      logic exception_level;
      logic irq_global_enable;
   } pscr_status_type;

   localparam logic [7:0] PSCR_STATUS_OFFSET = 8'h0C;
   localparam logic [7:0] PSCR_EVT_STATUS_OFFSET = 8'h10;
   localparam logic [7:0] PSCR_EVT_MASK_OFFSET = 8'h14;

   localparam logic [31:0] PSCR_STATUS_WMASK = 32'hF4C7_9C1F;
   localparam logic [31:0] PSCR_STATUS_RESET = 32'h0040_0004;
   localparam logic [1:0] PSCR_MODE_KERNEL = 2'h0;

   // Event bits of the sticky status register
   localparam int PSCR_EVT_COP_FAULT = 0;
   localparam int PSCR_EVT_IRQ_TAKEN = 1;
   localparam int PSCR_EVT_CACHE_DONE = 2;
   localparam int PSCR_EVT_W = 3;
   localparam logic [PSCR_EVT_W-1:0] PSCR_EVT_RESET = 3'h0;

   // Interrupt source bits: 2 timer, 1..0 external inputs
   localparam int PSCR_IRQ_TIMER = 2;
   localparam int PSCR_IRQ_W = 3;

endpackage

//--- verilog/pscr_status_ctrl.sv
// Processor status and control register with coprocessor and interrupt gating.
// Assumes privileged software drives the strobe port and the core pipeline
// drives the coprocessor, cache and pending inputs on the same clock.
//
// How it works
// - Four usability bits, one per coprocessor
// - Coprocessor zero always usable in kernel mode
// - Unusable coprocessor access raises an exception
// - Bit 26 picks 16 or 32 FP registers
// - Bit 23 places debug and counter vectors
// - Bit 22 places refill/general vectors, resets one
// - Bit 18 records last hit-invalidate result
// - Mask bits: timer at 15, externals 11:10
// - Interrupt needs mask, enable and pending
// - No software interrupts, three masked sources only
// - Software reads and writes every implemented bit
// - Reserved bits read back as zero
// - Global enable needs both enables, no levels
`timescale 1ns/1ps

module pscr_status_ctrl #(
   parameter int ADDR_W = 8
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic cop_access,
   input wire logic [1:0] cop_num,
   input wire logic cache_op_done,
   input wire logic cache_op_hit,
   input wire logic [pscr_pkg::PSCR_IRQ_W-1:0] irq_pending,
   output logic cop_unusable_exc,
   output logic [pscr_pkg::PSCR_IRQ_W-1:0] irq_take,
   output logic fp_reg_count_sel,
   output logic debug_vector_sel,
   output logic boot_vector_sel,
   output logic irq_out
);
   import pscr_pkg::*;

   if (ADDR_W < 5) begin : g_addr_check
      $error("ADDR_W too narrow for the register map");
   end

   pscr_status_type status_reg;
   pscr_status_type status_next;
   logic [PSCR_EVT_W-1:0] evt_reg;
   logic [PSCR_EVT_W-1:0] evt_next;
   logic [PSCR_EVT_W-1:0] evt_mask_reg;
   logic [PSCR_EVT_W-1:0] evt_mask_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic cop_exc_reg;
   logic cop_exc_next;
   logic [PSCR_IRQ_W-1:0] take_reg;
   logic [PSCR_IRQ_W-1:0] take_next;
   logic irq_reg;
   logic irq_next;

   logic [7:0] addr8;
   logic hit_status;
   logic hit_evt;
   logic hit_mask;
   logic kernel_mode;
   logic global_ok;
   logic [PSCR_IRQ_W-1:0] mask_vec;
   logic [PSCR_EVT_W-1:0] evt_set;

   assign addr8 = 8'(reg_addr);
   assign hit_status = (addr8 == PSCR_STATUS_OFFSET);
   assign hit_evt = (addr8 == PSCR_EVT_STATUS_OFFSET);
   assign hit_mask = (addr8 == PSCR_EVT_MASK_OFFSET);

   // Kernel when the mode field says so or either level bit is up
   assign kernel_mode = (status_reg.mode_sel == PSCR_MODE_KERNEL)
      || status_reg.exception_level || status_reg.error_level;

   assign global_ok = status_reg.irq_global_enable && status_reg.irq_enable_gate
      && !status_reg.exception_level && !status_reg.error_level;

   // Only three sources exist, so no software interrupt can be masked in
   assign mask_vec = {status_reg.irq_mask_timer, status_reg.irq_mask_ext};

   // Status word: software write, then hardware update of the hit flag
   always_comb begin
      status_next = status_reg;
      if (reg_write && hit_status) begin
         status_next = pscr_status_type'(reg_wdata & PSCR_STATUS_WMASK);
      end
      if (cache_op_done) begin
         status_next.cache_hit_flag = cache_op_hit;
      end
   end

   // Undefined fields also get a plain reset so outputs are never unknown
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         status_reg <= pscr_status_type'(PSCR_STATUS_RESET);
      end else begin
         status_reg <= status_next;
      end
   end

   // Coprocessor check and interrupt recognition
   always_comb begin
      cop_exc_next = 1'b0;
      if (cop_access) begin
         cop_exc_next = !status_reg.coproc_usable[cop_num];
         if (cop_num == 2'h0 && kernel_mode) begin
            cop_exc_next = 1'b0;
         end
      end
      take_next = global_ok ? (mask_vec & irq_pending) : '0;
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cop_exc_reg <= 1'b0;
         take_reg <= '0;
      end else begin
         cop_exc_reg <= cop_exc_next;
         take_reg <= take_next;
      end
   end

   // Sticky events; a set in the clearing cycle wins over the clear
   always_comb begin
      evt_set = '0;
      evt_set[PSCR_EVT_COP_FAULT] = cop_exc_next;
      evt_set[PSCR_EVT_IRQ_TAKEN] = |take_next;
      evt_set[PSCR_EVT_CACHE_DONE] = cache_op_done;
      evt_next = evt_reg;
      evt_mask_next = evt_mask_reg;
      if (reg_write && hit_evt) begin
         evt_next = evt_reg & ~reg_wdata[PSCR_EVT_W-1:0];
      end
      if (reg_write && hit_mask) begin
         evt_mask_next = reg_wdata[PSCR_EVT_W-1:0];
      end
      evt_next = evt_next | evt_set;
      irq_next = |(evt_next & evt_mask_next);
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         evt_reg <= PSCR_EVT_RESET;
         evt_mask_reg <= PSCR_EVT_RESET;
         irq_reg <= 1'b0;
      end else begin
         evt_reg <= evt_next;
         evt_mask_reg <= evt_mask_next;
         irq_reg <= irq_next;
      end
   end

   // Read port: data stand one cycle after the strobe, zero otherwise
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (reg_read) begin
         if (hit_status) begin
            rdata_next = 32'(status_reg) & PSCR_STATUS_WMASK;
         end else if (hit_evt) begin
            rdata_next = 32'(evt_reg);
         end else if (hit_mask) begin
            rdata_next = 32'(evt_mask_reg);
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign cop_unusable_exc = cop_exc_reg;
   assign irq_take = take_reg;
   assign irq_out = irq_reg;
   assign fp_reg_count_sel = status_reg.fp_reg_count_sel;
   assign debug_vector_sel = status_reg.debug_vector_sel;
   assign boot_vector_sel = status_reg.boot_vector_sel;

   a_cop_usable: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      cop_access && status_reg.coproc_usable[cop_num] |=> !cop_unusable_exc)
      else $error("usable coprocessor faulted");

   a_kernel_cop_zero: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      cop_access && cop_num == 2'h0 && kernel_mode |=> !cop_unusable_exc)
      else $error("coprocessor zero faulted in kernel mode");

   a_cop_fault: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      cop_access && !status_reg.coproc_usable[cop_num]
      && !(cop_num == 2'h0 && kernel_mode) |=> cop_unusable_exc ##1 !cop_unusable_exc
      or cop_unusable_exc ##1 $past(cop_access))
      else $error("unusable coprocessor access not faulted");

   a_fp_count_write: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      reg_write && hit_status |=> fp_reg_count_sel == $past(reg_wdata[26]))
      else $error("register count select not written");

   a_debug_vec_write: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      reg_write && hit_status |=> debug_vector_sel == $past(reg_wdata[23]))
      else $error("debug vector select not written");

   a_boot_vec_write: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      reg_write && hit_status && !cache_op_done |=> boot_vector_sel == $past(reg_wdata[22]))
      else $error("boot vector select not written");

   a_cache_hit_flag: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      cache_op_done ##1 (!cache_op_done && !(reg_write && hit_status))
      |-> status_reg.cache_hit_flag == $past(cache_op_hit))
      else $error("hit flag lost or wrong");

   a_timer_mask: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      irq_take[PSCR_IRQ_TIMER] |-> $past(status_reg.irq_mask_timer)
      && $past(irq_pending[PSCR_IRQ_TIMER]))
      else $error("timer taken while masked");

   a_irq_recognise: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      global_ok && (mask_vec & irq_pending) != '0 |=> irq_take != '0 && evt_reg[PSCR_EVT_IRQ_TAKEN])
      else $error("enabled pending interrupt not taken");

   a_read_back: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      reg_write && hit_status && !cache_op_done ##1 reg_read && hit_status
      |=> reg_rdata == ($past(reg_wdata, 2) & PSCR_STATUS_WMASK))
      else $error("status read back differs");

   a_global_gate: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      irq_take != '0 |-> $past(status_reg.irq_global_enable && status_reg.irq_enable_gate
      && !status_reg.exception_level && !status_reg.error_level))
      else $error("interrupt taken while globally disabled");

   a_irq_level: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (evt_reg & evt_mask_reg) != '0 && !(reg_write && (hit_evt || hit_mask)) |=> irq_out)
      else $error("interrupt output dropped while event pending");

   a_fault_event: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      cop_unusable_exc |-> evt_reg[PSCR_EVT_COP_FAULT])
      else $error("coprocessor fault left no event");

   a_exc_no_access: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      !cop_access |=> !cop_unusable_exc)
      else $error("coprocessor fault without an access");

   a_cache_event: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      cache_op_done |=> evt_reg[PSCR_EVT_CACHE_DONE])
      else $error("cache operation left no event");

   a_ext_mask: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      irq_take[1:0] != 2'h0
      |-> irq_take[1:0] == ($past(status_reg.irq_mask_ext) & $past(irq_pending[1:0])))
      else $error("external interrupt taken while masked");

   a_gate_closed: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      !global_ok |=> irq_take == '0)
      else $error("interrupt taken with the global gate closed");

   a_rsv_read_zero: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      reg_read && hit_status |=> (reg_rdata & ~PSCR_STATUS_WMASK) == 32'h0000_0000)
      else $error("reserved status bits read nonzero");

   a_rdata_idle: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      !reg_read |=> reg_rdata == 32'h0000_0000)
      else $error("read data outside the answer cycle");

   a_select_hold: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      !(reg_write && hit_status)
      |=> $stable(fp_reg_count_sel) && $stable(debug_vector_sel) && $stable(boot_vector_sel))
      else $error("select output changed without a write");

   a_irq_out_low: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (evt_next & evt_mask_next) == '0 |=> !irq_out)
      else $error("interrupt output high with no unmasked event");

   a_evt_mask_write: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      reg_write && hit_mask |=> evt_mask_reg == $past(reg_wdata[PSCR_EVT_W-1:0]))
      else $error("event mask not written");

endmodule

//--- verification/pscr_core_model.sv
// Core-side model: coprocessor accesses, cache op results, pending lines.
// Assumes its tasks are called from the ref_clk domain.
`timescale 1ns/1ps
module pscr_core_model (
   input wire logic ref_clk,
   output logic cop_access,
   output logic [1:0] cop_num,
   output logic cache_op_done,
   output logic cache_op_hit,
   output logic [pscr_pkg::PSCR_IRQ_W-1:0] irq_pending
);
   import pscr_pkg::*;
   initial begin
      cop_access = 1'b0;
      cop_num = 2'h0;
      cache_op_done = 1'b0;
      cache_op_hit = 1'b0;
      irq_pending = '0;
   end
   task automatic cop(input logic [1:0] n);
      @(posedge ref_clk);
      cop_access <= 1'b1;
      cop_num <= n;
      @(posedge ref_clk);
      cop_access <= 1'b0;
      // Number is stale once the access is gone, so show its inverse
      cop_num <= ~n;
   endtask
   task automatic cache(input logic hit);
      @(posedge ref_clk);
      cache_op_done <= 1'b1;
      cache_op_hit <= hit;
      @(posedge ref_clk);
      cache_op_done <= 1'b0;
      cache_op_hit <= ~hit;
   endtask
   task automatic pend(input logic [PSCR_IRQ_W-1:0] p);
      @(posedge ref_clk);
      irq_pending <= p;
   endtask
endmodule

//--- verification/processor_status_control_tb_top.sv
// Bench for the status register bank: register port tasks plus core model.
// Assumes one 200 MHz clock and a one-cycle read latency.
`timescale 1ns/1ps
module processor_status_control_tb_top;
   import pscr_pkg::*;
   logic ref_clk;
   logic sys_rst;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_write;
   logic reg_read;
   logic [31:0] reg_rdata;
   logic cop_access, cache_op_done, cache_op_hit, exc, fp_sel, dbg_sel, boot_sel, irq_out;
   logic [1:0] cop_num;
   logic [PSCR_IRQ_W-1:0] irq_pending, irq_take;
   logic [31:0] st[6] = '{32'h0001_8C01, 32'h0001_8001, 32'h0001_0C01, 32'h0001_0401,
                          32'h0001_8C00, 32'h0001_8C03};
   logic [2:0] tk[6] = '{3'h7, 3'h4, 3'h3, 3'h1, 3'h0, 3'h0};
   int n_fail = 0;
   int checked = 0;
   always #2.5 ref_clk = ~ref_clk;
   pscr_core_model core (.ref_clk(ref_clk), .cop_access(cop_access), .cop_num(cop_num),
      .cache_op_done(cache_op_done), .cache_op_hit(cache_op_hit), .irq_pending(irq_pending));
   pscr_status_ctrl i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .cop_access(cop_access), .cop_num(cop_num),
      .cache_op_done(cache_op_done), .cache_op_hit(cache_op_hit), .irq_pending(irq_pending),
      .cop_unusable_exc(exc), .irq_take(irq_take), .fp_reg_count_sel(fp_sel),
      .debug_vector_sel(dbg_sel), .boot_vector_sel(boot_sel), .irq_out(irq_out));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1 chk("reg_rdata", reg_rdata, e);
   endtask
   // Write then read with no gap between the strobes
   task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1 chk("reg_rdata_b2b", reg_rdata, e);
   endtask
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #20000;
      n_fail++;
      final_report();
   end
   initial begin
      ref_clk = 1'b0;
      sys_rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd(8'h0C, 32'h0040_0004);
      chk("vector_sel", {29'h0, fp_sel, dbg_sel, boot_sel}, 32'h1);
      wr_rd(8'h0C, 32'hFFFF_FFFF, 32'hF4C7_9C1F);
      chk("vector_sel", {29'h0, fp_sel, dbg_sel, boot_sel}, 32'h7);
      @(posedge ref_clk);
      #1 chk("reg_rdata_idle", reg_rdata, 32'h0);
      rd(8'h1C, 32'h0);
      wr(8'h14, 32'h3);
      // User mode with one usable coprocessor at a time
      for (int n = 0; n < 4; n++) begin
         wr(8'h0C, {4'h1 << n, 28'h000_0010});
         core.cop(n[1:0]);
         #1 chk("cop_usable", {31'h0, exc}, 32'h0);
         core.cop(n[1:0] + 2'h1);
         #1 chk("cop_unusable", {31'h0, exc}, 32'h1);
         chk("irq_out_fault", {31'h0, irq_out}, 32'h1);
      end
      // Error level alone makes kernel mode, even with user mode selected
      wr(8'h0C, 32'h0000_0014);
      core.cop(2'h0);
      #1 chk("system_control_coproc_error_level", {31'h0, exc}, 32'h0);
      wr(8'h0C, 32'h0000_0000);
      core.cop(2'h0);
      #1 chk("system_control_coproc_kernel", {31'h0, exc}, 32'h0);
      core.cop(2'h2);
      #1 chk("cop2_kernel", {31'h0, exc}, 32'h1);
      rd(8'h10, 32'h1);
      wr(8'h10, 32'h1);
      rd(8'h10, 32'h0);
      chk("irq_out_clear", {31'h0, irq_out}, 32'h0);
      core.cache(1'b1);
      rd(8'h0C, 32'h0004_0000);
      core.cache(1'b0);
      rd(8'h0C, 32'h0000_0000);
      core.pend(3'h7);
      for (int i = 0; i < 6; i++) begin
         wr(8'h0C, st[i]);
         @(posedge ref_clk);
         #1 chk("irq_take", {29'h0, irq_take}, {29'h0, tk[i]});
      end
      chk("irq_out_event", {31'h0, irq_out}, 32'h1);
      core.pend(3'h0);
      wr(8'h10, 32'h7);
      @(posedge ref_clk);
      #1 chk("irq_out_cleared", {31'h0, irq_out}, 32'h0);
      final_report();
   end
endmodule
